/* src/ecs_ctrl.sv */
// Configuration store controller: save/reload between buffer bank and nonvolatile memory
// What this block does
// - The transfer status bit reads 1 while a save or load runs and 0 once it has finished.
// - With the status source select set, the busy bit also drives the status pin.
// - A read-only error bit goes to 1 when bad data arrives during a load, and 0 means clean.
// - With the select pin low, setting the reload bit resets the device from stored settings.
// - Saves are refused while the unlock bit is 0, its reset value; only 1 allows them.
// - A save trigger bit copies the buffer registers into the nonvolatile memory.
// - Setting the trigger starts the save, and the controller clears it when the save ends.
// - A segment entry with bit 7 clear holds length minus one, then a two-byte address, MSB first.
// - A command with bit 7 set is a commit or an end of data, and end of data stops the walk.
// - A commit copies buffer into active registers on the next serial clock rising edge.
`timescale 1ns/100ps
module ecs_ctrl #(
	parameter int GAP = ecs_pkg::GAP_CYC
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Serial port register access
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Pins and status routing
	input wire logic eeprom_sel_n_pin,
	input wire logic sclk_pin,
	input wire logic status_sel,
	input wire logic status_alt,
	output logic status_pin,
	// Buffer register bank
	output logic cfg_rd,
	output logic cfg_wr,
	output logic [15:0] cfg_addr,
	output logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic cfg_rvalid,
	output logic cfg_commit,
	output logic soft_rst,
	// Nonvolatile memory
	output logic ee_rd,
	output logic ee_wvalid,
	input wire logic ee_wready,
	output logic [15:0] ee_addr,
	output logic [7:0] ee_wdata,
	input wire logic ee_rvalid,
	input wire logic [7:0] ee_rdata,
	input wire logic ee_rerr
);
	// Elaboration check; the quiet-gap counter is sixteen bits wide
	if (GAP < 1 || GAP > 65535) begin : g_bad_gap
		$error("ecs_ctrl: GAP out of range");
	end

	ecs_pkg::ecs_state_t state_r, ret_r;
	logic unlock_r, reload_r, save_r, busy_r, err_r, load_r;
	logic [7:0] seg_ptr_r, seg_q;
	logic [6:0] cnt_r;
	logic [7:0] iss_r;
	logic [15:0] addr_r, drn_addr_r, eptr_r;
	logic pend_r, commit_pend_r, sclk_prev_r, rd_p_r;
	logic [11:0] rd_a_r;
	logic [15:0] gap_r;
	logic [1:0] pin_in, pin_flt;
	logic idle_ok, req_save, req_load, start, issue, resp, pop, drain_idle, xfer_done;
	logic sclk_rise, seg_we;

	ecs_strm_if #(.W(ecs_pkg::DATA_W)) f_in ();
	ecs_strm_if #(.W(ecs_pkg::DATA_W)) f_out ();

	// Pin synchronisers; a change counts once the second and third stages agree
	assign pin_in = {sclk_pin, eeprom_sel_n_pin};
	for (genvar g = 0; g < 2; g++) begin : g_sync
		logic [2:0] sy_r;
		logic f_r;
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				sy_r <= {3{ecs_pkg::SYNC_RST[g]}};
				f_r <= ecs_pkg::SYNC_RST[g];
			end else if (ce) begin
				sy_r <= {sy_r[1:0], pin_in[g]};
				if (sy_r[2] == sy_r[1]) f_r <= sy_r[2];
			end
		end
		assign pin_flt[g] = f_r;
	end

	assign sclk_rise = pin_flt[1] && !sclk_prev_r;

	// Start decode; the quiet gap guards the memory even if the host rushes
	assign idle_ok = !busy_r && (gap_r == '0);
	assign req_save = ce && reg_wr && reg_addr == ecs_pkg::ADR_SAVE
		&& reg_wdata[ecs_pkg::BIT_SAVE] && unlock_r && idle_ok;
	assign req_load = ce && reg_wr && reg_addr == ecs_pkg::ADR_RELOAD
		&& reg_wdata[ecs_pkg::BIT_RELOAD] && !pin_flt[0] && idle_ok;
	assign start = req_save || req_load;

	// Per-byte handshakes
	assign issue = state_r == ecs_pkg::S_XFER && !pend_r && f_in.ready && iss_r <= {1'b0, cnt_r};
	assign resp = pend_r && (load_r ? ee_rvalid : cfg_rvalid);
	assign f_in.data = load_r ? ee_rdata : cfg_rdata;
	assign f_in.valid = resp;
	assign f_out.ready = load_r || !ee_wvalid || ee_wready;
	assign pop = f_out.valid && f_out.ready;
	assign drain_idle = !f_out.valid && !ee_wvalid;
	assign xfer_done = iss_r == {1'b0, cnt_r} + 8'h01 && !pend_r && drain_idle;
	assign seg_we = ce && reg_wr && reg_addr[11:8] == ecs_pkg::SEG_PAGE && !busy_r;

	ecs_fifo #(.W(ecs_pkg::DATA_W), .DEPTH(ecs_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.wr(f_in),
		.rd(f_out)
	);

	ecs_seg_mem #(.W(ecs_pkg::DATA_W), .DEPTH(ecs_pkg::SEG_DEPTH)) u_seg (
		.clk_sys(clk_sys),
		.ce(ce),
		.we(seg_we),
		.waddr(reg_addr[7:0]),
		.wdata(reg_wdata),
		.raddr(busy_r ? seg_ptr_r : reg_addr[7:0]),
		.q(seg_q)
	);

	// Software control bits and self-clearing triggers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			unlock_r <= ecs_pkg::RST_UNLOCK;
			reload_r <= 1'b0;
			save_r <= 1'b0;
			load_r <= 1'b0;
			soft_rst <= 1'b0;
		end else if (ce) begin
			if (reg_wr && reg_addr == ecs_pkg::ADR_RELOAD) begin
				unlock_r <= reg_wdata[ecs_pkg::BIT_UNLOCK];
			end
			soft_rst <= req_load;
			if (start) load_r <= req_load;
			// Self-clearing bits drop in the cycle after done; a request cannot meet done
			reload_r <= req_load || (reload_r && state_r != ecs_pkg::S_DONE);
			save_r <= req_save || (save_r && state_r != ecs_pkg::S_DONE);
		end
	end

	// Busy, error and quiet gap
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			err_r <= 1'b0;
			gap_r <= '0;
		end else if (ce) begin
			busy_r <= start || (busy_r && state_r != ecs_pkg::S_DONE);
			// Set beats clear, though both cannot meet in one cycle
			err_r <= (resp && load_r && ee_rerr) || (err_r && !start);
			// Reloaded on done so a hasty host cannot restart too soon
			if (state_r == ecs_pkg::S_DONE) gap_r <= 16'(GAP);
			else if (gap_r != '0) gap_r <= gap_r - 16'h0001;
		end
	end

	// Segment walker: reads take one cycle, so every pointer move except the one in S_ADRL passes S_WAIT
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= ecs_pkg::S_IDLE;
			ret_r <= ecs_pkg::S_CMD;
			seg_ptr_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			unique case (state_r)
				ecs_pkg::S_IDLE: begin
					seg_ptr_r <= '0;
					ret_r <= ecs_pkg::S_CMD;
					if (start) state_r <= ecs_pkg::S_WAIT;
				end
				ecs_pkg::S_WAIT: state_r <= ret_r;
				ecs_pkg::S_CMD: begin
					if (!seg_q[ecs_pkg::BIT_OPCODE]) begin
						cnt_r <= seg_q[6:0];
						seg_ptr_r <= seg_ptr_r + 8'h01;
						ret_r <= ecs_pkg::S_ADRH;
						state_r <= ecs_pkg::S_WAIT;
					end else if (seg_q == ecs_pkg::OP_COMMIT && seg_ptr_r != 8'hff) begin
						seg_ptr_r <= seg_ptr_r + 8'h01;
						ret_r <= ecs_pkg::S_CMD;
						state_r <= ecs_pkg::S_WAIT;
					end else begin
						state_r <= ecs_pkg::S_DONE;
					end
				end
				ecs_pkg::S_ADRH: begin
					seg_ptr_r <= seg_ptr_r + 8'h01;
					ret_r <= ecs_pkg::S_ADRL;
					state_r <= ecs_pkg::S_WAIT;
				end
				ecs_pkg::S_ADRL: begin
					seg_ptr_r <= seg_ptr_r + 8'h01;
					state_r <= ecs_pkg::S_XFER;
				end
				ecs_pkg::S_XFER: begin
					if (xfer_done) state_r <= ecs_pkg::S_CMD;
				end
				ecs_pkg::S_DONE: state_r <= ecs_pkg::S_IDLE;
				default: begin
					state_r <= ecs_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Byte issue and response tracking; one request in flight keeps FIFO room assured
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_r <= '0;
			drn_addr_r <= '0;
			iss_r <= '0;
			pend_r <= 1'b0;
			eptr_r <= '0;
		end else if (ce) begin
			if (start) eptr_r <= '0;
			if (state_r == ecs_pkg::S_ADRH) addr_r[15:8] <= seg_q;
			if (state_r == ecs_pkg::S_ADRH) drn_addr_r[15:8] <= seg_q;
			if (state_r == ecs_pkg::S_ADRL) begin
				addr_r[7:0] <= seg_q;
				drn_addr_r[7:0] <= seg_q;
				iss_r <= '0;
			end
			if (issue) begin
				addr_r <= addr_r + 16'h0001;
				iss_r <= iss_r + 8'h01;
				pend_r <= 1'b1;
			end else if (resp) begin
				pend_r <= 1'b0;
			end
			if (pop && load_r) drn_addr_r <= drn_addr_r + 16'h0001;
			if ((issue && load_r) || (pop && !load_r)) eptr_r <= eptr_r + 16'h0001;
		end
	end

	// Output strobes toward the bank and the nonvolatile memory
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg_rd <= 1'b0;
			cfg_wr <= 1'b0;
			cfg_addr <= '0;
			cfg_wdata <= '0;
			ee_rd <= 1'b0;
			ee_wvalid <= 1'b0;
			ee_addr <= '0;
			ee_wdata <= '0;
		end else if (ce) begin
			cfg_rd <= issue && !load_r;
			ee_rd <= issue && load_r;
			cfg_wr <= pop && load_r;
			if (issue && !load_r) cfg_addr <= addr_r;
			if (pop && load_r) begin
				cfg_addr <= drn_addr_r;
				cfg_wdata <= f_out.data;
			end
			if (issue && load_r) ee_addr <= eptr_r;
			if (pop && !load_r) begin
				ee_wvalid <= 1'b1;
				ee_wdata <= f_out.data;
				ee_addr <= eptr_r;
			end else if (ee_wready) ee_wvalid <= 1'b0;
		end
	end

	// Commit waits for a serial clock rising edge; the walk does not stall on it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_prev_r <= 1'b0;
			commit_pend_r <= 1'b0;
			cfg_commit <= 1'b0;
		end else if (ce) begin
			sclk_prev_r <= pin_flt[1];
			cfg_commit <= commit_pend_r && sclk_rise;
			if (state_r == ecs_pkg::S_CMD && seg_q == ecs_pkg::OP_COMMIT) begin
				commit_pend_r <= 1'b1;
			end else if (sclk_rise) begin
				commit_pend_r <= 1'b0;
			end
		end
	end

	// Register read path, two cycles to match the segment memory
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_p_r <= 1'b0;
			rd_a_r <= '0;
			reg_rvalid <= 1'b0;
			reg_rdata <= '0;
			status_pin <= 1'b0;
		end else if (ce) begin
			rd_p_r <= reg_rd;
			rd_a_r <= reg_addr;
			reg_rvalid <= rd_p_r;
			status_pin <= status_sel ? busy_r : status_alt;
			unique case (rd_a_r)
				ecs_pkg::ADR_STATE: reg_rdata <= 8'(busy_r);
				ecs_pkg::ADR_INTEG: reg_rdata <= 8'(err_r);
				ecs_pkg::ADR_RELOAD: reg_rdata <= {6'h00, reload_r, unlock_r};
				ecs_pkg::ADR_SAVE: reg_rdata <= 8'(save_r);
				default: reg_rdata <= (rd_a_r[11:8] == ecs_pkg::SEG_PAGE) ? seg_q : 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_busy_start: assert property (start |=> busy_r)
		else $error("busy not raised on start");
	chk_busy_end: assert property ($fell(busy_r) |-> $past(state_r) == ecs_pkg::S_DONE)
		else $error("busy dropped outside done");
	chk_status_route: assert property (ce && status_sel |=> status_pin == $past(busy_r))
		else $error("status pin does not follow busy");
	chk_err_set: assert property (ce && resp && load_r && ee_rerr |=> err_r)
		else $error("error flag missed bad data");
	chk_reload_pin: assert property (soft_rst |-> $past(pin_flt[0]) == 1'b0)
		else $error("reload while select pin high");
	chk_save_locked: assert property ($rose(busy_r) && !load_r |-> $past(unlock_r))
		else $error("save started while locked");
	chk_save_clear: assert property ($fell(save_r) |-> $past(state_r) == ecs_pkg::S_DONE)
		else $error("save trigger cleared early");
	chk_len_bound: assert property (state_r == ecs_pkg::S_XFER |-> iss_r <= {1'b0, cnt_r} + 8'h01)
		else $error("more bytes issued than entry length");
	chk_commit_edge: assert property (cfg_commit |-> $past(sclk_rise) && $past(commit_pend_r))
		else $error("commit not on serial clock edge");
	chk_busy_ignore: assert property (busy_r && ce |-> !start)
		else $error("transfer restarted while busy");
endmodule

/* include/ecs_pkg.sv */
// Shared constants and types for the configuration store controller
package ecs_pkg;
	// Control register addresses on the serial port map
	localparam logic [11:0] ADR_STATE = 12'hb00;
	localparam logic [11:0] ADR_INTEG = 12'hb01;
	localparam logic [11:0] ADR_RELOAD = 12'hb02;
	localparam logic [11:0] ADR_SAVE = 12'hb03;
	// Buffer segment window 0xa00..0xaff
	localparam logic [3:0] SEG_PAGE = 4'ha;
	// Field positions
	localparam int BIT_BUSY = 0;
	localparam int BIT_ERR = 0;
	localparam int BIT_UNLOCK = 0;
	localparam int BIT_RELOAD = 1;
	localparam int BIT_SAVE = 0;
	localparam int BIT_OPCODE = 7;
	// Reset values
	localparam logic RST_UNLOCK = 1'b0;
	localparam logic [1:0] SYNC_RST = 2'h1;
	// Operational codes of the buffer segment
	localparam logic [7:0] OP_COMMIT = 8'h80;
	localparam logic [7:0] OP_END = 8'hff;
	// Data path sizes
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int SEG_DEPTH = 256;
	// Quiet gap after a transfer
	localparam int CLK_MHZ = 50;
	localparam int GAP_NS = 10000;
	localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
	// Controller states, one-hot
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_WAIT = 7'h02,
		S_CMD = 7'h04,
		S_ADRH = 7'h08,
		S_ADRL = 7'h10,
		S_XFER = 7'h20,
		S_DONE = 7'h40
	} ecs_state_t;
endpackage

/* include/ecs_strm_if.sv */
// Valid/ready byte stream between the controller and its FIFO
`timescale 1ns/100ps
interface ecs_strm_if #(parameter int W = 8) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

/* src/ecs_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ecs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	// Clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Streams
	ecs_strm_if.snk wr,
	ecs_strm_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	// Elaboration check; the pointers wrap by overflow, so only powers of two work
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ecs_fifo: DEPTH must be a power of two >= 2");
	end

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// Honest flags straight from the fill count
	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data = mem_r[rp_r];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	// Storage, no reset needed on the data words
	always_ff @(posedge clk_sys) begin
		if (ce && push) begin
			mem_r[wp_r] <= wr.data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* src/ecs_seg_mem.sv */
// Buffer segment storage, one write port and a registered read port
`timescale 1ns/100ps
module ecs_seg_mem #(
	parameter int W = 8,
	parameter int DEPTH = 256
) (
	// Clock
	input wire logic clk_sys,
	input wire logic ce,
	// Write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [W-1:0] q
);
	// Power up as all end-of-data so an untouched segment ends at once
	logic [W-1:0] mem_r [DEPTH] = '{default: '1};

	// Write then registered read
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (we) mem_r[waddr] <= wdata;
			q <= mem_r[raddr];
		end
	end
endmodule

/* sim/ecs_ee_model.sv */
// Behavioural nonvolatile byte memory standing behind the controller
`timescale 1ns/100ps
module ecs_ee_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Stall and fault injection from the bench
	input wire logic stall,
	input wire logic [15:0] bad_addr,
	// Memory side
	input wire logic ee_rd,
	input wire logic ee_wvalid,
	output logic ee_wready,
	input wire logic [15:0] ee_addr,
	input wire logic [7:0] ee_wdata,
	output logic ee_rvalid,
	output logic [7:0] ee_rdata,
	output logic ee_rerr
);
	logic [7:0] mem [int];
	int n_wr = 0;
	// Stalls make the controller hold its write data for several cycles
	assign ee_wready = !stall;
	// Store accepted bytes; contents survive reset as the real part's would
	always @(posedge clk_sys) begin
		if (rst_n && ee_wvalid && ee_wready) begin
			mem[ee_addr] = ee_wdata;
			n_wr++;
		end
	end
	// Answer one cycle later; between answers the data lines keep changing
	initial ee_rdata = 8'h5a;
	always @(posedge clk_sys) begin
		ee_rvalid <= rst_n && ee_rd;
		if (rst_n && ee_rd)
			ee_rdata <= mem.exists(ee_addr) ? mem[ee_addr] : 8'hff;
		else
			ee_rdata <= ~ee_rdata;
		ee_rerr <= rst_n && ee_rd && (ee_addr == bad_addr);
	end
endmodule

/* sim/eeprom_config_store_control_test.sv */
// Self-checking bench for the configuration store controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module eeprom_config_store_control_test;
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic sel_n = 1'b1, sclk = 1'b0, status_sel = 1'b0, status_alt = 1'b0;
	logic cfg_rvalid = 1'b0, stall = 1'b0, stall_en = 1'b0, ce = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00, cfg_rdata = 8'h00, rv;
	logic [15:0] bad = 16'hffff;
	wire logic [7:0] reg_rdata, cfg_wdata, ee_wdata, ee_rdata;
	wire logic [15:0] cfg_addr, ee_addr;
	wire logic reg_rvalid, status_pin, cfg_rd, cfg_wr, cfg_commit, soft_rst;
	wire logic ee_rd, ee_wvalid, ee_wready, ee_rvalid, ee_rerr;
	integer seed = 32'h3bbd;
	int n_errors = 0, total_checks = 0, cyc = 0, n_stat = 0, n_cmt = 0, n_srst = 0;
	int i, ncmt;
	logic [7:0] bank [int];
	logic [7:0] seg [$];
	int expa [$];
	logic [7:0] orig [$];

	ecs_ctrl #(.GAP(4)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .eeprom_sel_n_pin(sel_n),
		.sclk_pin(sclk), .status_sel(status_sel), .status_alt(status_alt),
		.status_pin(status_pin), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.cfg_commit(cfg_commit), .soft_rst(soft_rst), .ee_rd(ee_rd), .ee_wvalid(ee_wvalid),
		.ee_wready(ee_wready), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rvalid(ee_rvalid),
		.ee_rdata(ee_rdata), .ee_rerr(ee_rerr));
	ecs_ee_model mdl (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .bad_addr(bad),
		.ee_rd(ee_rd), .ee_wvalid(ee_wvalid), .ee_wready(ee_wready), .ee_addr(ee_addr),
		.ee_wdata(ee_wdata), .ee_rvalid(ee_rvalid), .ee_rdata(ee_rdata), .ee_rerr(ee_rerr));

	// 50 MHz clock
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// Buffer bank answers next cycle; its data lines wander when idle
	always @(posedge clk_sys) begin
		cfg_rvalid <= (cfg_rd === 1'b1);
		cfg_rdata <= (cfg_rd === 1'b1) ? bank[cfg_addr] : ~cfg_rdata;
		if (cfg_wr === 1'b1)
			bank[cfg_addr] = cfg_wdata;
		n_cmt += (cfg_commit === 1'b1);
		n_srst += (soft_rst === 1'b1);
		n_stat += (status_pin === 1'b1 && status_sel);
	end
	// Slow serial clock, random memory stalls, and a hang limit
	always @(posedge clk_sys) begin
		cyc++;
		sclk <= cyc[3];
		stall <= stall_en ? 1'($random(seed)) : 1'b0;
		if (cyc == 20000) begin
			n_errors++;
			complete_run;
		end
	end

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		int k;
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		d = 8'hxx;
		for (k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			#1;
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				break;
			end
		end
		// Return on an edge so callers drive their next inputs there
		@(posedge clk_sys);
	endtask
	task automatic chkrd(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK("register read", e, d)
	endtask
	// Poll the busy bit; a transfer that never ends counts as a mismatch
	task automatic wait_idle();
		int k;
		logic [7:0] d;
		for (k = 0; k < 3000; k++) begin
			rd(12'hb00, d);
			if (d === 8'h00)
				return;
		end
		n_errors++;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		// Segment: 3-byte entry, commit, 1-byte entry, end of data
		seg = '{8'h02, 8'h00, 8'h10, 8'h80, 8'h00, 8'h01, 8'h20, 8'hff};
		ncmt = 0;
		i = 0;
		while (seg[i] != 8'hff) begin
			if (seg[i][7]) begin
				ncmt++;
				i++;
			end else begin
				for (int j = 0; j <= seg[i]; j++)
					expa.push_back({seg[i+1], seg[i+2]} + j);
				i += 3;
			end
		end
		foreach (expa[k])
			bank[expa[k]] = 8'($random(seed));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// Reset values and an unmapped address
		chkrd(12'hb00, 8'h00);
		chkrd(12'hb01, 8'h00);
		chkrd(12'hb02, 8'h00);
		chkrd(12'hb03, 8'h00);
		chkrd(12'hb04, 8'h00);
		foreach (seg[k])
			wr(12'ha00 + 12'(k), seg[k]);
		// Locked save must not reach the memory
		wr(12'hb03, 8'h01);
		repeat (20) @(posedge clk_sys);
		`CHK("locked writes", 0, mdl.n_wr)
		chkrd(12'hb00, 8'h00);
		// Unlocked save with a stalling memory, busy shown on the status pin
		status_sel <= 1'b1;
		stall_en <= 1'b1;
		wr(12'hb02, 8'h01);
		wr(12'hb03, 8'h01);
		chkrd(12'hb03, 8'h01);
		chkrd(12'hb00, 8'h01);
		wr(12'hb03, 8'h01);
		wait_idle();
		stall_en <= 1'b0;
		`CHK("saved bytes", expa.size(), mdl.n_wr)
		foreach (expa[k])
			`CHK("saved data", bank[expa[k]], mdl.mem[k])
		chkrd(12'hb03, 8'h00);
		`CHK("status pin busy", 1'b1, n_stat > 0)
		status_sel <= 1'b0;
		repeat (40) @(posedge clk_sys);
		`CHK("commits", ncmt, n_cmt)
		// Reload refused while the select pin is high
		wr(12'hb02, 8'h03);
		repeat (20) @(posedge clk_sys);
		`CHK("refused reload", 0, n_srst)
		// Reload with one corrupted byte, then a clean one
		sel_n <= 1'b0;
		bad <= 16'h0001;
		foreach (expa[k]) begin
			orig.push_back(bank[expa[k]]);
			bank[expa[k]] = ~bank[expa[k]];
		end
		repeat (10) @(posedge clk_sys);
		wr(12'hb02, 8'h03);
		wait_idle();
		`CHK("soft reset", 1, n_srst)
		chkrd(12'hb01, 8'h01);
		chkrd(12'hb02, 8'h01);
		repeat (40) @(posedge clk_sys);
		bad <= 16'hffff;
		wr(12'hb02, 8'h03);
		wait_idle();
		chkrd(12'hb01, 8'h00);
		foreach (expa[k])
			`CHK("restored data", orig[k], bank[expa[k]])
		// The last commit may still wait for a serial clock rise
		repeat (40) @(posedge clk_sys);
		`CHK("commits", 2 * ncmt, n_cmt - ncmt)
		// Alternate status source when the busy routing is off
		status_alt <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("status pin alt", 1'b1, status_pin)
		// Clock enable low freezes the pin although its source changes
		@(posedge clk_sys);
		ce <= 1'b0;
		status_alt <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK("frozen status pin", 1'b1, status_pin)
		@(posedge clk_sys);
		ce <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("released status pin", 1'b0, status_pin)
		complete_run;
	end
endmodule
